// >>> rtl/pss_sram_port.sv
// pipelined synchronous sram port: command pipeline, burst count, pins
// Operation
// - advance high steps the burst counter
// - advance low loads the new address
// - act on rising edge only when qualified
// - selected only with all three selects active
// - output enable high forces pins to input
// - no drive on write data, deselect cycles
// - high qualifier freezes every internal state
// - input lanes captured on the rising edge
// - read data one recognised edge after address
// - parity lanes match data, per-lane select
// - load is write when strobe low
// - byte lane selects gate lane writes
// - strap picks interleaved or linear burst order
`timescale 1ns/1ps
`default_nettype none
module pss_sram_port
(
	input  wire logic                          sys_clk,          // clock
	input  wire logic                          rst_b,            // sync reset
	input  wire logic [pss_pkg::ADDR_W-1:0]    address,          // address
	input  wire logic                          advanceLoadSelect,// 1 step
	input  wire logic                          clockQualifierN,  // edge mask
	input  wire logic                          chipSelectOneN,   // select 1
	input  wire logic                          chipSelectTwo,    // select 2
	input  wire logic                          chipSelectThreeN, // select 3
	input  wire logic                          writeStrobeN,     // write
	input  wire logic [pss_pkg::LANES-1:0]     byteLaneSelectN,  // lanes
	input  wire logic                          outputEnableN,    // async oe
	input  wire logic                          burstOrderMode,   // strap
	input  wire logic [pss_pkg::DATA_W-1:0]    dataIn,           // pin in
	output var  logic [pss_pkg::DATA_W-1:0]    dataOut,          // pin out
	output var  logic                          dataOe,           // pin drive
	input  wire logic [pss_pkg::PAR_W-1:0]     parityIn,         // pin in
	output var  logic [pss_pkg::PAR_W-1:0]     parityOut,        // pin out
	output var  logic                          parityOe          // pin drive
);
	localparam int AW = pss_pkg::ADDR_W;
	localparam int CW = pss_pkg::BURST_W;

	typedef struct packed
	{
		logic                           interleave;
		logic                           s1Valid;
		logic                           s1Write;
		logic [AW-1:0]                  s1Addr;
		logic [pss_pkg::LANES-1:0]      s1Be;
		logic                           burstActive;
		logic                           burstWrite;
		logic [AW-1:0]                  baseAddr;
		logic [CW-1:0]                  burstCnt;
		logic                           s2Write;
		logic [AW-1:0]                  s2Addr;
		logic [pss_pkg::LANES-1:0]      s2Be;
		logic                           drive;
		logic [pss_pkg::WORD_W-1:0]     outWord;
	} pss_state_t;

	pss_state_t stateQ;
	pss_state_t stateD;

	logic          selected;
	logic          edgeLive;
	logic [CW-1:0] nextCnt;
	logic [CW-1:0] nextLow;
	logic [AW-1:0] burstAddr;

	pss_mem_if memIf ();

	pss_word_store uStore
	(
		.sys_clk (sys_clk),
		.memIf   (memIf.store)
	);

	assign edgeLive = !clockQualifierN;

	assign selected = !chipSelectOneN && chipSelectTwo && !chipSelectThreeN;

	assign nextCnt = stateQ.burstCnt + pss_pkg::BURST_STEP;
	assign nextLow = stateQ.interleave
		? (stateQ.baseAddr[CW-1:0] ^ nextCnt)
		: CW'(stateQ.baseAddr[CW-1:0] + nextCnt);
	assign burstAddr = {stateQ.baseAddr[AW-1:CW], nextLow};

	// write data taken from pins at the data edge
	assign memIf.wrEn   = edgeLive && stateQ.s2Write;
	assign memIf.wrAddr = stateQ.s2Addr;
	// lane selects sampled with the command
	assign memIf.wrBe   = stateQ.s2Be;
	// parity rides in the same word
	assign memIf.wrData = {parityIn, dataIn};
	assign memIf.rdAddr = stateQ.s1Addr;

	always_comb
	begin
		stateD = stateQ;
		if (!rst_b)
		begin
			stateD = '0;
			// strap caught while reset is held, fixed afterwards
			stateD.interleave = burstOrderMode;
			stateD.s1Addr     = pss_pkg::ADDR_RESET;
			stateD.baseAddr   = pss_pkg::ADDR_RESET;
			stateD.s2Addr     = pss_pkg::ADDR_RESET;
			stateD.burstCnt   = pss_pkg::BURST_RESET;
			stateD.s1Be       = pss_pkg::LANES_NONE;
			stateD.s2Be       = pss_pkg::LANES_NONE;
			stateD.outWord    = pss_pkg::WORD_RESET;
		end
		else if (edgeLive)
		begin
			// data stage follows the command stage
			stateD.s2Write = stateQ.s1Valid && stateQ.s1Write;
			stateD.s2Addr  = stateQ.s1Addr;
			stateD.s2Be    = stateQ.s1Be;
			// read word one edge behind address
			stateD.drive   = stateQ.s1Valid && !stateQ.s1Write;
			if (stateQ.s1Valid && !stateQ.s1Write)
			begin
				stateD.outWord = memIf.rdData;
			end
			if (!selected)
			begin
				stateD.s1Valid     = 1'b0;
				stateD.s1Write     = 1'b0;
				stateD.burstActive = 1'b0;
			end
			else if (!advanceLoadSelect)
			begin
				stateD.s1Valid     = 1'b1;
				stateD.s1Addr      = address;
				stateD.baseAddr    = address;
				stateD.burstCnt    = pss_pkg::BURST_RESET;
				stateD.burstActive = 1'b1;
				stateD.s1Write     = !writeStrobeN;
				stateD.burstWrite  = !writeStrobeN;
				stateD.s1Be        = ~byteLaneSelectN;
			end
			else if (stateQ.burstActive)
			begin
				stateD.s1Valid  = 1'b1;
				stateD.s1Addr   = burstAddr;
				stateD.burstCnt = nextCnt;
				stateD.s1Write  = stateQ.burstWrite;
				stateD.s1Be     = ~byteLaneSelectN;
			end
			// advance with no open burst does nothing
			else
			begin
				stateD.s1Valid = 1'b0;
				stateD.s1Write = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		stateQ <= stateD;
	end

	// output enable is asynchronous, so it gates the registered drive
	// drive only in a read data slot
	assign dataOe    = stateQ.drive && !outputEnableN;
	assign parityOe  = stateQ.drive && !outputEnableN;
	assign dataOut   = stateQ.outWord[pss_pkg::DATA_W-1:0];
	assign parityOut = stateQ.outWord[pss_pkg::WORD_W-1:pss_pkg::DATA_W];

	default clocking cbMain @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_freeze_holds_state: assert property (
		clockQualifierN |=> $stable(stateQ))
		else $error("state moved on a masked edge");

	a_deselect_no_drive: assert property (
		(edgeLive && !selected) ##1 edgeLive |=> !dataOe && !parityOe)
		else $error("pins driven after a deselect");

	a_write_slot_quiet: assert property (
		(edgeLive && selected && !advanceLoadSelect && !writeStrobeN)
		##1 edgeLive |=> !stateQ.drive)
		else $error("pins driven in write data slot");

	a_read_slot_drives: assert property (
		(edgeLive && selected && !advanceLoadSelect && writeStrobeN)
		##1 edgeLive |=> stateQ.drive
		&& stateQ.outWord == $past(memIf.rdData))
		else $error("read word missing one edge after address");

	a_oe_forces_input: assert property (
		(outputEnableN || !stateQ.drive) |-> !dataOe && !parityOe)
		else $error("pins driven while disabled");

	a_load_takes_addr: assert property (
		(edgeLive && selected && !advanceLoadSelect) |=>
		stateQ.s1Addr == $past(address) && stateQ.burstCnt == 2'h0
		&& stateQ.s1Write == !$past(writeStrobeN))
		else $error("load did not take address or op");

	a_burst_steps_low: assert property (
		(edgeLive && selected && advanceLoadSelect && stateQ.burstActive)
		|=> stateQ.burstCnt == CW'($past(stateQ.burstCnt) + 2'h1)
		&& stateQ.s1Addr[AW-1:CW] == $past(stateQ.baseAddr[AW-1:CW]))
		else $error("burst step wrong");

	a_linear_order: assert property (
		(edgeLive && selected && advanceLoadSelect && stateQ.burstActive
		&& !stateQ.interleave) |=> stateQ.s1Addr[1:0]
		== CW'(stateQ.baseAddr[1:0] + stateQ.burstCnt))
		else $error("linear burst address wrong");

	a_write_lands: assert property (
		(edgeLive && selected && !advanceLoadSelect && !writeStrobeN)
		##1 edgeLive ##1 edgeLive |-> memIf.wrEn
		&& memIf.wrBe == $past(~byteLaneSelectN, 2))
		else $error("write lanes not applied");

	a_strap_fixed: assert property (
		1'b1 |=> $stable(stateQ.interleave))
		else $error("burst order changed in operation");

	a_interleave_order: assert property (
		(edgeLive && selected && advanceLoadSelect && stateQ.burstActive
		&& stateQ.interleave) |=> stateQ.s1Addr[1:0]
		== (stateQ.baseAddr[1:0] ^ stateQ.burstCnt))
		else $error("interleaved burst address wrong");

	a_deselect_closes: assert property (
		(edgeLive && !selected) |=> !stateQ.s1Valid && !stateQ.burstActive)
		else $error("deselect left an access open");

	a_idle_advance: assert property (
		(edgeLive && selected && advanceLoadSelect && !stateQ.burstActive)
		|=> !stateQ.s1Valid)
		else $error("advance without burst made an access");

	a_burst_keeps_op: assert property (
		(edgeLive && selected && advanceLoadSelect && stateQ.burstActive)
		|=> stateQ.s1Valid && stateQ.s1Write == $past(stateQ.burstWrite))
		else $error("burst step lost its operation");

	a_masked_no_write: assert property (
		clockQualifierN |-> !memIf.wrEn)
		else $error("write on a masked edge");

	a_drive_needs_read: assert property (
		(edgeLive && !(stateQ.s1Valid && !stateQ.s1Write)) |=> !stateQ.drive)
		else $error("drive without a read slot");

	a_parity_oe_match: assert property (
		parityOe == dataOe)
		else $error("parity drive differs from data drive");

	a_lane_select_taken: assert property (
		(edgeLive && selected && !advanceLoadSelect && !writeStrobeN)
		|=> stateQ.s1Be == ~$past(byteLaneSelectN))
		else $error("lane selects not taken with write");

	a_read_is_read: assert property (
		(edgeLive && selected && !advanceLoadSelect && writeStrobeN)
		|=> stateQ.s1Valid && !stateQ.s1Write)
		else $error("read load not taken as read");

	a_load_sets_base: assert property (
		(edgeLive && selected && !advanceLoadSelect)
		|=> stateQ.baseAddr == $past(address) && stateQ.burstActive)
		else $error("load did not open a burst");

	a_write_data_edge: assert property (
		(edgeLive && stateQ.s2Write)
		|-> memIf.wrEn && memIf.wrAddr == stateQ.s2Addr)
		else $error("write data edge missed");

	a_out_held_masked: assert property (
		clockQualifierN |=> $stable(dataOut) && $stable(parityOut))
		else $error("read word moved on a masked edge");

	a_write_stage_moves: assert property (
		(edgeLive && stateQ.s1Valid && stateQ.s1Write)
		|=> stateQ.s2Write && stateQ.s2Be == $past(stateQ.s1Be))
		else $error("write did not reach data stage");

	a_step_wraps: assert property (
		(edgeLive && selected && advanceLoadSelect && stateQ.burstActive
		&& stateQ.burstCnt == 2'h3) |=> stateQ.burstCnt == 2'h0)
		else $error("burst count did not wrap");
endmodule
`default_nettype wire

// >>> rtl/pss_pkg.sv
// constants shared by the pipelined synchronous sram port
package pss_pkg;
	localparam int DATA_W  = 32;
	localparam int LANES   = 4;
	localparam int PAR_W   = 4;
	localparam int WORD_W  = DATA_W + PAR_W;
	localparam int ADDR_W  = 19;
	localparam int BURST_W = 2;
	localparam int LANE_W  = 8;
	localparam logic [BURST_W-1:0] BURST_STEP   = 2'h1;
	localparam logic [BURST_W-1:0] BURST_RESET  = 2'h0;
	localparam logic [ADDR_W-1:0]  ADDR_RESET   = 19'h00000;
	localparam logic [WORD_W-1:0]  WORD_RESET   = 36'h000000000;
	localparam logic [LANES-1:0]   LANES_NONE   = 4'h0;
endpackage

// >>> rtl/pss_mem_if.sv
// write and read path between the port control and the word store
`timescale 1ns/1ps
`default_nettype none
interface pss_mem_if;
	logic                          wrEn;
	logic [pss_pkg::ADDR_W-1:0]    wrAddr;
	logic [pss_pkg::LANES-1:0]     wrBe;
	logic [pss_pkg::WORD_W-1:0]    wrData;
	logic [pss_pkg::ADDR_W-1:0]    rdAddr;
	logic [pss_pkg::WORD_W-1:0]    rdData;
	modport ctrl  (output wrEn, wrAddr, wrBe, wrData, rdAddr, input rdData);
	modport store (input wrEn, wrAddr, wrBe, wrData, rdAddr, output rdData);
endinterface
`default_nettype wire

// >>> rtl/pss_word_store.sv
// word array with byte-lane writes and write-to-read forwarding
`timescale 1ns/1ps
`default_nettype none
module pss_word_store
(
	input  wire logic sys_clk,    // port clock
	pss_mem_if.store  memIf       // write and read requests
);
	localparam int DEPTH = 1 << pss_pkg::ADDR_W;

	logic [pss_pkg::WORD_W-1:0] mem [DEPTH];
	logic [pss_pkg::WORD_W-1:0] oldWr;
	logic [pss_pkg::WORD_W-1:0] oldRd;
	logic [pss_pkg::WORD_W-1:0] mergedWr;
	logic [pss_pkg::WORD_W-1:0] mergedRd;
	logic                       rdHit;

	assign oldWr = mem[memIf.wrAddr];
	assign oldRd = mem[memIf.rdAddr];
	// a read issued right behind a write to the same word sees new data
	assign rdHit = memIf.wrEn && (memIf.wrAddr == memIf.rdAddr);

	genvar g;
	generate
		for (g = 0; g < pss_pkg::LANES; g++)
		begin : gLane
			localparam int LO = g * pss_pkg::LANE_W;
			localparam int PB = pss_pkg::DATA_W + g;
			assign mergedWr[LO +: pss_pkg::LANE_W] = memIf.wrBe[g]
				? memIf.wrData[LO +: pss_pkg::LANE_W]
				: oldWr[LO +: pss_pkg::LANE_W];
			// parity bit follows the lane select of its own byte
			assign mergedWr[PB] = memIf.wrBe[g] ? memIf.wrData[PB] : oldWr[PB];
			assign mergedRd[LO +: pss_pkg::LANE_W] = (rdHit && memIf.wrBe[g])
				? memIf.wrData[LO +: pss_pkg::LANE_W]
				: oldRd[LO +: pss_pkg::LANE_W];
			assign mergedRd[PB] = (rdHit && memIf.wrBe[g])
				? memIf.wrData[PB] : oldRd[PB];
		end
	endgenerate

	assign memIf.rdData = mergedRd;

	always_ff @(posedge sys_clk)
	begin
		if (memIf.wrEn)
		begin
			mem[memIf.wrAddr] <= mergedWr;
		end
	end
endmodule
`default_nettype wire

// >>> verif/pss_ctrl_model.sv
// controller model that drives the sram port command and data pins
`timescale 1ns/1ps
`default_nettype none
module pss_ctrl_model
(
	input  wire logic        sys_clk, // port clock
	output var  logic [18:0] addr,    // access address
	output var  logic        adv,     // 1 advances burst
	output var  logic        cqN,     // edge mask
	output var  logic [2:0]  sel,     // {cs1n, cs2, cs3n}
	output var  logic        wrN,     // write strobe
	output var  logic [3:0]  laneN,   // lane selects
	output var  logic        oeN,     // output enable
	output var  logic [35:0] drvVal   // level seen when the port is quiet
);
	logic [1:0]  wPipe = 2'h0;
	logic [71:0] dPipe = 72'h0;
	initial
	begin
		{addr, adv, cqN, sel, wrN, laneN} = 29'h0;
		oeN = 1'b0;
		drvVal = 36'h0;
	end
	task automatic op(input logic [2:0] s, input logic a, input logic w,
		input logic [18:0] ad, input logic [3:0] b, input logic [35:0] d);
		@(posedge sys_clk);
		#1;
		{cqN, sel, adv, wrN, addr, laneN} = {1'b0, s, a, w, ad, b};
		// write data goes out two edges after the command edge
		drvVal = wPipe[1] ? dPipe[71:36] : ~drvVal;
		wPipe = {wPipe[0], s == 3'h2 && !w && !a};
		dPipe = {dPipe[35:0], d};
	endtask
	task automatic hold(input int n);
		cqN = 1'b1;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/test_pipelined_sync_sram_port.sv
// self-checking bench for the pipelined synchronous sram port
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_sync_sram_port;
	localparam logic [2:0]  SEL    = 3'h2;
	localparam logic [18:0] BASE   = 19'h00104;
	localparam logic [35:0] MERGED = 36'h9c3220044;
	logic        sys_clk;
	logic        rst_b;
	logic        burstOrderMode;
	logic [18:0] addr;
	logic        adv;
	logic        cqN;
	logic [2:0]  sel;
	logic        wrN;
	logic [3:0]  laneN;
	logic        oeN;
	logic [35:0] drvVal;
	logic [31:0] dataOut;
	logic        dataOe;
	logic [3:0]  parityOut;
	logic        parityOe;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cycles = 0;
	wire  logic [31:0] dataPin = dataOe ? dataOut : drvVal[31:0];
	wire  logic [3:0]  parityPin = parityOe ? parityOut : drvVal[35:32];
	pss_sram_port i_dut
	(
		.sys_clk          (sys_clk),
		.rst_b            (rst_b),
		.address          (addr),
		.advanceLoadSelect(adv),
		.clockQualifierN  (cqN),
		.chipSelectOneN   (sel[2]),
		.chipSelectTwo    (sel[1]),
		.chipSelectThreeN (sel[0]),
		.writeStrobeN     (wrN),
		.byteLaneSelectN  (laneN),
		.outputEnableN    (oeN),
		.burstOrderMode   (burstOrderMode),
		.dataIn           (dataPin),
		.dataOut          (dataOut),
		.dataOe           (dataOe),
		.parityIn         (parityPin),
		.parityOut        (parityOut),
		.parityOe         (parityOe)
	);
	pss_ctrl_model i_ctrl
	(
		.sys_clk(sys_clk),
		.addr   (addr),
		.adv    (adv),
		.cqN    (cqN),
		.sel    (sel),
		.wrN    (wrN),
		.laneN  (laneN),
		.oeN    (oeN),
		.drvVal (drvVal)
	);
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [35:0] exp);
		cmp({parityOut, dataOut}, exp);
		cmp({34'h0, dataOe, parityOe}, 36'h3);
	endtask
	task automatic off();
		cmp({34'h0, dataOe, parityOe}, 36'h0);
	endtask
	task automatic des(input int n);
		repeat (n)
			i_ctrl.op(3'h0, 1'b0, 1'b1, 19'h0, 4'hf, 36'h0);
	endtask
	function automatic logic [35:0] pat(input int i);
		return {4'(i + 1), 32'hc3a50000 + 32'(i)};
	endfunction
	task automatic doReset(input logic mode);
		rst_b = 1'b0;
		burstOrderMode = mode;
		repeat (8) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
	endtask
	task automatic t_write_read();
		i_ctrl.op(SEL, 1'b0, 1'b0, BASE, 4'h0, pat(7));
		i_ctrl.op(SEL, 1'b0, 1'b1, BASE, 4'hf, 36'h0);
		des(1);
		off();
		des(1);
		rd(pat(7));
		des(1);
		off();
	endtask
	task automatic t_lanes();
		i_ctrl.op(SEL, 1'b0, 1'b0, BASE, 4'ha, 36'h311223344);
		i_ctrl.op(SEL, 1'b0, 1'b1, BASE, 4'hf, 36'h0);
		des(2);
		rd(MERGED);
	endtask
	task automatic t_oe();
		i_ctrl.oeN = 1'b1;
		i_ctrl.op(SEL, 1'b0, 1'b1, BASE, 4'hf, 36'h0);
		des(2);
		off();
		i_ctrl.oeN = 1'b0;
		#1;
		rd(MERGED);
	endtask
	task automatic t_sel();
		for (int k = 0; k < 3; k++)
		begin
			i_ctrl.op(SEL ^ (3'h1 << k), 1'b0, 1'b1, BASE, 4'hf, 36'h0);
			des(2);
			off();
		end
	endtask
	task automatic t_freeze();
		i_ctrl.op(SEL, 1'b0, 1'b1, BASE, 4'hf, 36'h0);
		des(1);
		i_ctrl.hold(3);
		off();
		des(2);
		rd(MERGED);
		i_ctrl.hold(3);
		rd(MERGED);
		des(2);
		off();
	endtask
	task automatic t_burst(input logic mode);
		doReset(mode);
		for (int i = 0; i < 4; i++)
			i_ctrl.op(SEL, 1'b0, 1'b0, BASE + 19'(i), 4'h0, pat(i));
		i_ctrl.op(SEL, 1'b0, 1'b1, BASE + 19'h1, 4'hf, 36'h0);
		for (int k = 0; k < 5; k++)
		begin
			if (k < 3)
				i_ctrl.op(SEL, 1'b1, 1'b1, 19'h7ffff, 4'hf, 36'h0);
			else
				des(1);
			if (k > 0)
				rd(pat(mode ? 1 ^ (k - 1) : k % 4));
		end
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			mismatches++;
			print_verdict();
		end
	end
	initial
	begin
		t_burst(1'b0);
		t_write_read();
		t_lanes();
		t_oe();
		t_sel();
		t_freeze();
		t_burst(1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
